// [logic/capture_if.sv]
// carries interval tick and caught levels between sampler modules
// assumes: one clock domain
`timescale 1ns/10ps

interface capture_if;
  import din_sampler_pkg::*;
  logic tick;
  logic clear;
  port_word_t caught;
  modport timer (output tick, output clear, input caught);
  modport catcher (input tick, input clear, output caught);
endinterface : capture_if

// [logic/din_sampler.sv]
// sixteen-bit digital input port sampler top
// assumes: div_i held stable while enabled; consumer always ready
`timescale 1ns/10ps
`include "din_sampler_cfg.svh"

module din_sampler
  import din_sampler_pkg::*;
#(
  parameter int WIDTH = `PORT_WIDTH,
  parameter int DIVW = `DIV_WIDTH,
  parameter int MIN_DIV = `MIN_INTERVAL_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // comparator pins, input one on bit 0
  input wire logic [WIDTH-1:0] comp_i,
  // configuration
  input wire logic capture_en_i,
  input wire logic reduce_en_i,
  input wire logic [DIVW-1:0] div_i,
  // sample stream
  output logic sample_valid_o,
  output logic [WIDTH-1:0] input_port_word_o,
  output logic [WIDTH-1:0] input_bit_channels_o,
  output logic input_bit_first_o,
  output logic input_bit_last_o,
  // indicators
  output logic [WIDTH-1:0] led_green_o
);

  // ==========================================================
  // interval timer
  capture_if cap ();

  logic [DIVW-1:0] cnt_ff;
  logic [DIVW-1:0] period;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] port_ff;
  logic [WIDTH-1:0] last_ff;
  logic have_last_ff;
  logic valid_ff;
  logic nxt_emit;

  // faster than the top rate is clamped rather than refused [RQ4]
  assign period = (div_i < DIVW'(MIN_DIV)) ? DIVW'(MIN_DIV) : div_i;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= '0;
    end else if (!capture_en_i || cap.tick) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + DIVW'(1);
    end
  end

  // one tick per interval while enabled [RQ3] [RQ4]
  assign cap.tick = capture_en_i && (cnt_ff == period - DIVW'(1));
  // catch latches restart from the live level while off [RQ6]
  assign cap.clear = !capture_en_i;

  pulse_catcher #(
    .WIDTH(WIDTH)
  ) u_catcher (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .comp_i(comp_i),
    .cap(cap),
    .level_o(level)
  );

  // ==========================================================
  // sample stream
  // reduction compares with the last emitted word, not last sampled [RQ7]
  assign nxt_emit = cap.tick && (!reduce_en_i || !have_last_ff || cap.caught != last_ff);

  // whole port taken as one word, no bit enables [RQ1] [RQ5]
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_ff <= WIDTH'(`PORT_RESET);
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= nxt_emit;
      if (nxt_emit) begin
        port_ff <= cap.caught;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_ff <= WIDTH'(`PORT_RESET);
      have_last_ff <= 1'b0;
    end else if (!capture_en_i) begin
      have_last_ff <= 1'b0;
    end else if (nxt_emit) begin
      last_ff <= cap.caught;
      have_last_ff <= 1'b1;
    end
  end

  assign sample_valid_o = valid_ff;
  assign input_port_word_o = port_ff; // [RQ1]
  assign input_bit_channels_o = port_ff; // [RQ2]
  assign input_bit_first_o = port_ff[0]; // [RQ2] [RQ9]
  assign input_bit_last_o = port_ff[WIDTH-1]; // [RQ2]
  // indicator follows the live filtered level [RQ8]
  assign led_green_o = level;

endmodule : din_sampler

// [logic/din_sampler_cfg.svh]
// constants for the digital input port sampler
// assumes: included by bare name from the package and modules
//
// Behaviour
// RQ1 - pack sixteen inputs into one unsigned word
// RQ2 - each input also given as separate bit
// RQ3 - enabled port samples continuously at set rate
// RQ4 - sampling rates up to ten kilohertz
// RQ5 - whole port always captured, no bit enables
// RQ6 - any high within interval reported in sample; a high seen at only one clock edge is filtered out before the latch
// RQ7 - reduction mode emits only changed values
// RQ8 - bit one and indicator lit when high
// RQ9 - catch latch clears at capture, input one lsb
`ifndef DIN_SAMPLER_CFG_SVH
`define DIN_SAMPLER_CFG_SVH

// ==========================================================
// widths and timing
`define PORT_WIDTH 16
`define CLK_PERIOD_NS 50
`define MAX_RATE_HZ 10000
// shortest interval at the top rate: 100 us -> 2000 cycles
`define MIN_INTERVAL_NS (1000000000 / `MAX_RATE_HZ)
`define MIN_INTERVAL_CYC (`MIN_INTERVAL_NS / `CLK_PERIOD_NS)
`define DIV_WIDTH 24
`define DEFAULT_DIV 24'h0007d0
`define PORT_RESET 16'h0000

`endif

// [logic/din_sampler_pkg.sv]
// types shared by the sampler modules
// assumes: cfg header on the include path
`include "din_sampler_cfg.svh"

package din_sampler_pkg;

  // ==========================================================
  // types
  typedef logic [`PORT_WIDTH-1:0] port_word_t;
  typedef logic [`DIV_WIDTH-1:0] div_t;

endpackage : din_sampler_pkg

// [logic/pulse_catcher.sv]
// per-bit synchroniser and high-level catch latch
// assumes: raw comparator outputs, asynchronous to core_clk_i
`timescale 1ns/10ps
`include "din_sampler_cfg.svh"

module pulse_catcher
  import din_sampler_pkg::*;
#(
  parameter int WIDTH = `PORT_WIDTH
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // comparator pins
  input wire logic [WIDTH-1:0] comp_i,
  // capture link
  capture_if.catcher cap,
  // filtered levels for indicators
  output logic [WIDTH-1:0] level_o
);

  // ==========================================================
  // per-bit sync and latch
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff;
      logic latch_ff;

      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
        end else begin
          s1_ff <= comp_i[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end

      // change accepted only when second and third stage agree
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          lvl_ff <= 1'b0;
        end else if (s2_ff == s3_ff) begin
          lvl_ff <= s3_ff;
        end
      end

      // clear beats set but reloads the level: a high in the tick cycle lands in the next word only [RQ6] [RQ9]
      // while off the latch tracks the level, so old highs never reach a word [RQ6]
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          latch_ff <= 1'b0;
        end else if (cap.clear || cap.tick) begin
          latch_ff <= lvl_ff;
        end else if (lvl_ff) begin
          latch_ff <= 1'b1;
        end
      end

      // latch alone, so a high held across a tick is reported in both words [RQ6] [RQ9]
      assign cap.caught[g] = latch_ff;
      assign level_o[g] = lvl_ff;
    end
  endgenerate

endmodule : pulse_catcher

// [tb/din_sampler_asserts.sv]
// port checks for the sampler top
// assumes: bound to din_sampler, div_i at least four
`timescale 1ns/10ps
module din_sampler_asserts (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // pins and stream
  input wire logic [15:0] comp_i,
  input wire logic capture_en_i,
  input wire logic sample_valid_o,
  input wire logic [15:0] input_port_word_o,
  input wire logic [15:0] input_bit_channels_o,
  input wire logic input_bit_first_o,
  input wire logic input_bit_last_o,
  input wire logic [15:0] led_green_o
);
  // ==========
  // properties
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_PULSE: assert property (sample_valid_o |=> !sample_valid_o)
    else $error("valid too long");
  AST_GAP: assert property (sample_valid_o |=> !sample_valid_o [*3])
    else $error("samples too close");
  AST_IDLE: assert property (!capture_en_i [*2] |-> !sample_valid_o)
    else $error("sample while off");
  AST_HOLD: assert property (!sample_valid_o |-> $stable(input_port_word_o))
    else $error("word moved");
  AST_BITS: assert property (input_bit_channels_o == input_port_word_o)
    else $error("bit view differs");
  AST_FIRST: assert property (input_bit_first_o == input_port_word_o[0])
    else $error("first bit differs");
  AST_LAST: assert property (input_bit_last_o == input_port_word_o[15])
    else $error("last bit differs");
  // sync lag is 3-4 cycles, so six steady cycles suffice
  AST_LED: assert property ($stable(comp_i) [*6] |-> led_green_o == comp_i)
    else $error("indicator differs");
endmodule : din_sampler_asserts

// [tb/sample_sink.sv]
// consumer model tallying emitted words
// assumes: always ready, sampler clock
`timescale 1ns/10ps
module sample_sink (
  // clock, reset and stream
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] word_i,
  // tallies
  output logic [15:0] count_o,
  output logic [15:0] last_o
);
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= 16'h0000;
      last_o <= 16'h0000;
    end else if (sample_valid_i) begin
      count_o <= count_o + 16'h0001;
      last_o <= word_i;
    end
  end
endmodule : sample_sink

// [tb/tb_top.sv]
// bench for the port sampler
// assumes: interval shortened to eight cycles
`timescale 1ns/10ps
module tb_top;
  import din_sampler_pkg::*;
  // ==========
  // wiring
  logic core_clk_i, reset_n_i, capture_en_i, reduce_en_i, sample_valid_o, b0, b15;
  port_word_t comp_i, word, chans, leds, count, last, c0;
  div_t div_i;
  int fails, check_count;
  din_sampler #(.MIN_DIV(4)) u_dut (.core_clk_i, .reset_n_i, .comp_i, .capture_en_i,
    .reduce_en_i, .div_i, .sample_valid_o, .input_port_word_o(word),
    .input_bit_channels_o(chans), .input_bit_first_o(b0), .input_bit_last_o(b15),
    .led_green_o(leds));
  sample_sink u_sink (.core_clk_i, .reset_n_i, .sample_valid_i(sample_valid_o),
    .word_i(word), .count_o(count), .last_o(last));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : step
  task automatic wait_valid();
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(posedge core_clk_i);
      #1;
      if (sample_valid_o === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    if (!seen) fails++;
  endtask : wait_valid
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // ==========
  // tests
  task automatic t_rate();
    comp_i = 16'h8001;
    step(6);
    c0 = count;
    capture_en_i = 1'b1;
    step(36);
    capture_en_i = 1'b0;
    chk(count - c0, 16'h0004);
    chk(word, 16'h8001);
    chk(chans, 16'h8001);
    chk({b15, 14'h0000, b0}, 16'h8001);
    chk(leds, 16'h8001);
    $display("rate test done");
  endtask : t_rate
  task automatic t_pulse();
    comp_i = 16'h0000;
    step(6);
    capture_en_i = 1'b1;
    wait_valid();
    chk(word, 16'h0000);
    comp_i = 16'h0008;
    step(2);
    comp_i = 16'h0000;
    wait_valid();
    chk(word, 16'h0008);
    wait_valid();
    chk(word, 16'h0000);
    capture_en_i = 1'b0;
    $display("pulse test done");
  endtask : t_pulse
  task automatic t_reduce();
    comp_i = 16'h00ff;
    reduce_en_i = 1'b1;
    step(6);
    c0 = count;
    capture_en_i = 1'b1;
    step(40);
    chk(count - c0, 16'h0001);
    comp_i = 16'h0fff;
    step(40);
    chk(count - c0, 16'h0002);
    chk(last, 16'h0fff);
    $display("reduce test done");
  endtask : t_reduce
  task automatic t_clamp();
    capture_en_i = 1'b0;
    reduce_en_i = 1'b0;
    div_i = 24'h000002;
    step(2);
    c0 = count;
    capture_en_i = 1'b1;
    step(20);
    capture_en_i = 1'b0;
    chk(count - c0, 16'h0004);
    $display("clamp test done");
  endtask : t_clamp
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    {reset_n_i, capture_en_i, reduce_en_i, fails, check_count} = '0;
    comp_i = 16'h0000;
    div_i = 24'h000008;
    step(6);
    reset_n_i = 1'b1;
    step(2);
    t_rate();
    t_pulse();
    t_reduce();
    t_clamp();
    print_verdict();
  end
endmodule : tb_top
bind din_sampler din_sampler_asserts u_chk (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .comp_i(comp_i),
  .capture_en_i(capture_en_i),
  .sample_valid_o(sample_valid_o),
  .input_port_word_o(input_port_word_o),
  .input_bit_channels_o(input_bit_channels_o),
  .input_bit_first_o(input_bit_first_o),
  .input_bit_last_o(input_bit_last_o),
  .led_green_o(led_green_o)
);
